// File: cfg_byte_fifo.sv
// Byte FIFO between parallel capture and the daisy serializer
`timescale 1ns/10ps
`include "cfg_seq_defines.svh"

module cfg_byte_fifo #(
    parameter int WIDTH = `BYTE_W,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PTR_W = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            wr;
        logic [PTR_W-1:0]            rd;
        logic [PTR_W:0]              count;
    } fifo_s;

    fifo_s r;
    fifo_s n;

    assign in_ready  = (r.count != (PTR_W+1)'(DEPTH));
    assign out_valid = (r.count != '0);
    assign out_data  = r.mem[r.rd];

    always_comb
    begin
        logic push;
        logic pop;
        push = in_valid && in_ready;
        pop  = out_valid && out_ready;
        n = r;
        if (push)
        begin
            n.mem[r.wr] = in_data;
            n.wr        = (r.wr == PTR_W'(DEPTH - 1)) ? '0 : r.wr + 1'b1;
        end
        if (pop)
        begin
            n.rd = (r.rd == PTR_W'(DEPTH - 1)) ? '0 : r.rd + 1'b1;
        end
        // Count moves only when exactly one side transfers
        if (push && !pop)
        begin
            n.count = r.count + 1'b1;
        end
        else if (pop && !push)
        begin
            n.count = r.count - 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    fifo_no_overflow_a: assert property (@(posedge clk) disable iff (srst)
        r.count <= (PTR_W+1)'(DEPTH))
        else $error("fifo count beyond depth");

endmodule

// File: cfg_far_side.sv
// Far-side model: configuration memory and upstream serial bit source
`timescale 1ns/10ps

module cfg_far_side #(
    parameter logic [31:0] PAT = 32'h9d2c5af1
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [17:0] addr,
    input  wire logic        strobe,
    input  wire logic        ser_clk,
    output logic [7:0]       data,
    output logic             ser_bit
);
    logic [17:0] addr_reg;
    logic [1:0]  wait_reg;
    logic [7:0]  last_reg;
    logic        ser_clk_reg;
    logic [4:0]  idx_reg;
    logic        valid;

    // valid only with strobe low
    // Released bus toggles so a late capture cannot pass by luck
    assign valid   = !strobe && (wait_reg == 2'h0) && (addr == addr_reg);
    assign data    = valid ? ((addr[7:0] * 8'h1d) ^ 8'h5a) : ~last_reg;
    assign ser_bit = PAT[idx_reg];

    always_ff @(posedge clk)
    begin
        addr_reg    <= addr;
        last_reg    <= data;
        ser_clk_reg <= ser_clk;
        if (!rst_n)
        begin
            wait_reg <= 2'h0;
            idx_reg  <= 5'h0;
        end
        else
        begin
            // Three cycles of access time after any address change
            if (addr != addr_reg)
                wait_reg <= 2'h2;
            else if (wait_reg != 2'h0)
                wait_reg <= wait_reg - 2'h1;
            if (ser_clk_reg && !ser_clk)
                idx_reg <= idx_reg + 5'h1;
        end
    end
endmodule

// File: cfg_seq_defines.svh
// Timing, width and encoding constants of the configuration sequencer
`ifndef CFG_SEQ_DEFINES_SVH
`define CFG_SEQ_DEFINES_SVH

`define MCLK_KHZ          20000
`define MCLK_PERIOD_NS    50
`define CONFIG_CLOCK_FAST_KHZ     10000
`define CONFIG_CLOCK_SLOW_KHZ     1250

`define HALF_FAST         (`MCLK_KHZ / (2 * `CONFIG_CLOCK_FAST_KHZ))
`define HALF_SLOW         (`MCLK_KHZ / (2 * `CONFIG_CLOCK_SLOW_KHZ))

`define CYC_MIN(ns)       (((ns) + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`define INIT_CLEAR_NS     63360
`define SLAVE_FIRST_NS    1000
`define MS_FIRST_NS       1060
`define MP_FIRST_FAST_NS  1120
`define MP_FIRST_SLOW_NS  5280

`define CNT_W             13
`define DIV_W             4
`define ADDR_W            18
`define BYTE_W            8
`define BITS_W            4
`define PHASE_W           3
`define FIFO_DEPTH        8

`define STROBE_LAST       3'h7
`define BITS_PER_BYTE     4'h8
`define MODE_PIN_MS       2'h0
`define MODE_PIN_MP       2'h1

`endif

// File: cfg_seq_pkg.sv
// Types shared by the configuration sequencer
package cfg_seq_pkg;

    typedef enum logic [1:0] {
        ST_PROG,
        ST_CLEAR,
        ST_WAIT,
        ST_RUN
    } seq_state_e;

    typedef enum logic [1:0] {
        MODE_MASTER_SERIAL,
        MODE_MASTER_PARALLEL,
        MODE_SLAVE_SERIAL
    } cfg_mode_e;

endpackage

// File: config_port_master_sequencer.sv
// Configuration port sequencer: clearing, init, config clock, byte fetch, daisy output
// What this block does
// - Parallel mode byte strobe: seven clocks low, then one clock high.
// - Fetched byte starts on daisy output 1.5 config clocks after capture.
// - Master serial: each captured input bit goes out on next falling edge.
// - Master config clock 10 MHz with rate select 0, 1.25 MHz with 1.
// - Byte captured from memory data bus on strobe rising edge.
// - First config clock edge 1.00 us after init (slave), 1.10 us master serial at either rate, 1.15-5.30 us master parallel.
// - After program input returns high, clear memory, then raise init after 63.40 us.
`timescale 1ns/10ps
`include "cfg_seq_defines.svh"

module config_port_master_sequencer (
    input  wire logic                 MCLK,
    input  wire logic                 SRST,
    input  wire logic                 PROGRAM_INPUT_N,
    input  wire logic [1:0]           MODE_SEL,
    input  wire logic                 CLOCK_RATE_SELECT,
    input  wire logic                 CONFIG_CLOCK_IN,
    output logic                      CONFIG_CLOCK_OUT,
    output logic                      CONFIG_CLOCK_OE_N,
    input  wire logic                 SERIAL_IN,
    input  wire logic [`BYTE_W-1:0]   MEM_DATA,
    output logic                      BYTE_READ_STROBE,
    output logic [`ADDR_W-1:0]        MEM_ADDR,
    output logic                      DAISY_OUT,
    output logic                      INIT_DONE
);
    typedef struct packed {
        cfg_seq_pkg::seq_state_e state;
        cfg_seq_pkg::cfg_mode_e  mode;
        logic                    rate_slow;
        logic [`CNT_W-1:0]       cnt;
        logic [`DIV_W-1:0]       div;
        logic                    config_clock;
        logic                    strobe;
        logic [`PHASE_W-1:0]     phase;
        logic [`ADDR_W-1:0]      addr;
        logic [`BYTE_W-1:0]      shift;
        logic [`BITS_W-1:0]      bits_left;
        logic                    ser_bit;
        logic                    daisy;
        logic                    init;
        logic [`BYTE_W-1:0]      last_byte;
        logic                    prog_s1;
        logic                    prog_s2;
        logic                    rate_s1;
        logic                    rate_s2;
        logic [1:0]              mode_s1;
        logic [1:0]              mode_s2;
        logic                    ser_s1;
        logic                    ser_s2;
        logic [`BYTE_W-1:0]      data_s1;
        logic [`BYTE_W-1:0]      data_s2;
        logic                    clk_s1;
        logic                    clk_s2;
        logic                    clk_prev;
    } seq_s;

    localparam seq_s RESET_STATE = '{
        state:   cfg_seq_pkg::ST_PROG,
        mode:    cfg_seq_pkg::MODE_MASTER_SERIAL,
        strobe:  1'b1,
        phase:   `STROBE_LAST,
        default: '0
    };

    seq_s                r;
    seq_s                n;
    logic                rise;
    logic                fall;
    logic                fifo_push;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic                fifo_pop_ready;
    logic [`BYTE_W-1:0]  fifo_out_data;

    function automatic cfg_seq_pkg::cfg_mode_e mode_decode(input logic [1:0] pins);
        if (pins == `MODE_PIN_MS)
        begin
            return cfg_seq_pkg::MODE_MASTER_SERIAL;
        end
        if (pins == `MODE_PIN_MP)
        begin
            return cfg_seq_pkg::MODE_MASTER_PARALLEL;
        end
        return cfg_seq_pkg::MODE_SLAVE_SERIAL;
    endfunction

    function automatic logic [`DIV_W-1:0] half_period(input logic slow);
        return slow ? `DIV_W'(`HALF_SLOW) : `DIV_W'(`HALF_FAST);
    endfunction

    function automatic logic [`CNT_W-1:0] first_wait(input cfg_seq_pkg::cfg_mode_e m,
                                                     input logic slow);
        case (m)
            cfg_seq_pkg::MODE_MASTER_SERIAL:   return `CNT_W'(`CYC_MIN(`MS_FIRST_NS));
            cfg_seq_pkg::MODE_MASTER_PARALLEL: return slow ?
                `CNT_W'(`CYC_MIN(`MP_FIRST_SLOW_NS)) : `CNT_W'(`CYC_MIN(`MP_FIRST_FAST_NS));
            default:                           return `CNT_W'(`CYC_MIN(`SLAVE_FIRST_NS));
        endcase
    endfunction

    function automatic logic is_master(input cfg_seq_pkg::cfg_mode_e m);
        return m != cfg_seq_pkg::MODE_SLAVE_SERIAL;
    endfunction

    always_comb
    begin
        n = r;
        rise = 1'b0;
        fall = 1'b0;
        fifo_push = 1'b0;
        fifo_pop_ready = 1'b0;
        // Pins pass two flops; the second stage is read, and the clock input also a third
        n.prog_s1 = PROGRAM_INPUT_N;
        n.prog_s2 = r.prog_s1;
        n.rate_s1 = CLOCK_RATE_SELECT;
        n.rate_s2 = r.rate_s1;
        n.mode_s1 = MODE_SEL;
        n.mode_s2 = r.mode_s1;
        n.ser_s1  = SERIAL_IN;
        n.ser_s2  = r.ser_s1;
        n.data_s1 = MEM_DATA;
        n.data_s2 = r.data_s1;
        n.clk_s1  = CONFIG_CLOCK_IN;
        n.clk_s2  = r.clk_s1;
        n.clk_prev = r.clk_s2;

        case (r.state)
            cfg_seq_pkg::ST_PROG:
            begin
                n.cnt = '0;
                if (r.prog_s2)
                begin
                    n.state = cfg_seq_pkg::ST_CLEAR;
                end
            end
            cfg_seq_pkg::ST_CLEAR:
            begin
                if (r.cnt == `CNT_W'(`CYC_MIN(`INIT_CLEAR_NS) - 1))
                begin
                    n.state = cfg_seq_pkg::ST_WAIT;
                    n.init  = 1'b1;
                    n.cnt   = '0;
                    n.mode      = mode_decode(r.mode_s2);
                    n.rate_slow = r.rate_s2;
                end
                else
                begin
                    n.cnt = r.cnt + 1'b1;
                end
            end
            cfg_seq_pkg::ST_WAIT:
            begin
                if (r.cnt == first_wait(r.mode, r.rate_slow) - 1'b1)
                begin
                    n.state = cfg_seq_pkg::ST_RUN;
                    n.div   = '0;
                    if (is_master(r.mode))
                    begin
                        n.config_clock = 1'b1;
                        rise   = 1'b1;
                    end
                end
                else
                begin
                    n.cnt = r.cnt + 1'b1;
                end
            end
            cfg_seq_pkg::ST_RUN:
            begin
                if (is_master(r.mode))
                begin
                    if (r.div == half_period(r.rate_slow) - 1'b1)
                    begin
                        n.div  = '0;
                        n.config_clock = ~r.config_clock;
                        rise   = ~r.config_clock;
                        fall   = r.config_clock;
                    end
                    else
                    begin
                        n.div = r.div + 1'b1;
                    end
                end
                else
                begin
                    // Edges seen on the synchronised copy, so lag by two cycles
                    rise = r.clk_s2 && !r.clk_prev;
                    fall = !r.clk_s2 && r.clk_prev;
                end
            end
            default:
            begin
                n.state = cfg_seq_pkg::ST_PROG;
            end
        endcase

        if (r.mode != cfg_seq_pkg::MODE_MASTER_PARALLEL)
        begin
            // capture on rise, forward on fall
            if (rise)
            begin
                n.ser_bit = r.ser_s2;
            end
            if (fall)
            begin
                n.daisy = r.ser_bit;
            end
        end
        else
        begin
            if (rise)
            begin
                if (r.phase == `STROBE_LAST)
                begin
                    // New period only with room for its byte; else strobe stays high
                    if (fifo_in_ready)
                    begin
                        n.phase  = '0;
                        n.strobe = 1'b0;
                    end
                end
                else
                begin
                    n.phase = r.phase + 1'b1;
                    if (r.phase == `STROBE_LAST - 1'b1)
                    begin
                        n.strobe = 1'b1;
                        fifo_push   = 1'b1;
                        n.last_byte = r.data_s2;
                        n.addr = r.addr + 1'b1;
                    end
                end
                fifo_pop_ready = (r.bits_left == '0);
                if (fifo_pop_ready && fifo_out_valid)
                begin
                    n.shift     = fifo_out_data;
                    n.bits_left = `BITS_PER_BYTE;
                end
            end
            if (fall && r.bits_left != '0)
            begin
                n.daisy     = r.shift[`BYTE_W-1];
                n.shift     = {r.shift[`BYTE_W-2:0], 1'b0};
                n.bits_left = r.bits_left - 1'b1;
            end
        end

        // Program input low restarts the whole sequence
        if (!r.prog_s2 && r.state != cfg_seq_pkg::ST_PROG)
        begin
            n = RESET_STATE;
            n.prog_s1 = PROGRAM_INPUT_N;
            n.rate_s1 = CLOCK_RATE_SELECT;
            n.mode_s1 = MODE_SEL;
            n.ser_s1  = SERIAL_IN;
            n.data_s1 = MEM_DATA;
            n.clk_s1  = CONFIG_CLOCK_IN;
            fifo_push      = 1'b0;
            fifo_pop_ready = 1'b0;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            r <= RESET_STATE;
        end
        else
        begin
            r <= n;
        end
    end

    cfg_byte_fifo #(
        .WIDTH (`BYTE_W),
        .DEPTH (`FIFO_DEPTH)
    ) byte_fifo (
        .clk       (MCLK),
        .srst      (SRST || (!r.prog_s2 && r.state != cfg_seq_pkg::ST_PROG)),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (r.data_s2),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop_ready),
        .out_data  (fifo_out_data)
    );

    assign CONFIG_CLOCK_OUT  = r.config_clock;
    assign CONFIG_CLOCK_OE_N = !(is_master(r.mode) && r.init);
    assign BYTE_READ_STROBE  = r.strobe;
    assign MEM_ADDR          = r.addr;
    assign DAISY_OUT         = r.daisy;
    assign INIT_DONE         = r.init;

    // Assertion helpers
    localparam int LOW_FAST  = 2 * `HALF_FAST * `STROBE_LAST;
    localparam int LOW_SLOW  = 2 * `HALF_SLOW * `STROBE_LAST;
    localparam int CLEAR_CYC = `CYC_MIN(`INIT_CLEAR_NS);
    localparam int MS_WAIT   = `CYC_MIN(`MS_FIRST_NS);
    logic [7:0]  low_cnt;
    logic [12:0] clear_time;
    logic        running;
    logic        parallel;

    assign running  = (r.state == cfg_seq_pkg::ST_RUN) && r.prog_s2;
    assign parallel = (r.mode == cfg_seq_pkg::MODE_MASTER_PARALLEL);

    always_ff @(posedge MCLK)
    begin
        low_cnt    <= (SRST || r.strobe) ? 8'h00 : low_cnt + 8'h01;
        clear_time <= (SRST || r.state != cfg_seq_pkg::ST_CLEAR) ? 13'h0000 : clear_time + 13'h0001;
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST || !r.prog_s2);

    sequence strobe_up_s;
        running && parallel && $rose(r.strobe);
    endsequence

    strobe_low_fast_a: assert property (strobe_up_s and !r.rate_slow |-> low_cnt == 8'(LOW_FAST))
        else $error("strobe low time wrong at fast rate");
    strobe_low_slow_a: assert property (strobe_up_s and r.rate_slow |-> low_cnt == 8'(LOW_SLOW))
        else $error("strobe low time wrong at slow rate");
    daisy_start_a: assert property (strobe_up_s and !r.rate_slow |->
            ##3 ($fell(r.config_clock) && r.bits_left == 4'h7))
        else $error("daisy shift not 1.5 clocks after capture");
    serial_forward_a: assert property (running && !parallel && is_master(r.mode)
            && $fell(r.config_clock) |-> r.daisy == $past(r.ser_bit))
        else $error("serial bit not forwarded on falling edge");
    clock_fast_a: assert property (running && is_master(r.mode) && !r.rate_slow
            && $rose(r.config_clock) |-> ##1 $fell(r.config_clock) ##1 $rose(r.config_clock))
        else $error("fast config clock period wrong");
    clock_slow_a: assert property (running && is_master(r.mode) && r.rate_slow
            && $rose(r.config_clock) |-> r.config_clock[*8] ##1 (!r.config_clock)[*8] ##1 r.config_clock)
        else $error("slow config clock period wrong");
    byte_capture_a: assert property (strobe_up_s |-> r.last_byte == $past(r.data_s2))
        else $error("byte not captured at strobe rise");
    first_edge_a: assert property ($rose(r.init) && r.rate_slow
            && r.mode == cfg_seq_pkg::MODE_MASTER_SERIAL |-> ##MS_WAIT $rose(r.config_clock))
        else $error("first config clock edge at wrong time");
    init_delay_a: assert property ($rose(r.init) |-> clear_time == 13'(CLEAR_CYC))
        else $error("init raised after wrong clearing time");
    addr_step_a: assert property (strobe_up_s |-> r.addr == $past(r.addr) + 18'h00001)
        else $error("address did not advance by one");

endmodule

// File: test_config_port_master_sequencer.sv
// Self-checking bench of the configuration port sequencer
`timescale 1ns/10ps
`include "cfg_seq_defines.svh"

`define CHECK(what, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("wrong value %s expected %h seen %h", what, exp, got); \
        end \
    end

module test_config_port_master_sequencer;
    localparam logic [31:0] PAT = 32'h9d2c5af1;

    logic                 MCLK              = 1'b0;
    logic                 SRST              = 1'b1;
    logic                 PROGRAM_INPUT_N   = 1'b1;
    logic [1:0]           MODE_SEL          = 2'h0;
    logic                 CLOCK_RATE_SELECT = 1'b0;
    logic                 CONFIG_CLOCK_IN   = 1'b0;
    logic                 CONFIG_CLOCK_OUT;
    logic                 CONFIG_CLOCK_OE_N;
    logic                 SERIAL_IN;
    logic [`BYTE_W-1:0]   MEM_DATA;
    logic                 BYTE_READ_STROBE;
    logic [`ADDR_W-1:0]   MEM_ADDR;
    logic                 DAISY_OUT;
    logic                 INIT_DONE;
    logic                 link_run          = 1'b0;
    logic                 slave_sel         = 1'b0;
    logic                 ser_clk;
    int                   fails             = 0;
    int                   total_checks      = 0;

    always #25 MCLK = ~MCLK;

    // Link clock unrelated in phase, stands low outside frames
    initial
    begin
        #37;
        forever
        begin
            #200;
            if (link_run || CONFIG_CLOCK_IN)
                CONFIG_CLOCK_IN = ~CONFIG_CLOCK_IN;
        end
    end

    assign ser_clk = slave_sel ? CONFIG_CLOCK_IN : CONFIG_CLOCK_OUT;

    config_port_master_sequencer DUT (
        .MCLK              (MCLK),
        .SRST              (SRST),
        .PROGRAM_INPUT_N   (PROGRAM_INPUT_N),
        .MODE_SEL          (MODE_SEL),
        .CLOCK_RATE_SELECT (CLOCK_RATE_SELECT),
        .CONFIG_CLOCK_IN   (CONFIG_CLOCK_IN),
        .CONFIG_CLOCK_OUT  (CONFIG_CLOCK_OUT),
        .CONFIG_CLOCK_OE_N (CONFIG_CLOCK_OE_N),
        .SERIAL_IN         (SERIAL_IN),
        .MEM_DATA          (MEM_DATA),
        .BYTE_READ_STROBE  (BYTE_READ_STROBE),
        .MEM_ADDR          (MEM_ADDR),
        .DAISY_OUT         (DAISY_OUT),
        .INIT_DONE         (INIT_DONE)
    );

    cfg_far_side #(
        .PAT (PAT)
    ) far_side (
        .clk     (MCLK),
        .rst_n   (PROGRAM_INPUT_N & ~SRST),
        .addr    (MEM_ADDR),
        .strobe  (BYTE_READ_STROBE),
        .ser_clk (ser_clk),
        .data    (MEM_DATA),
        .ser_bit (SERIAL_IN)
    );

    task automatic tick();
        @(posedge MCLK);
        #1;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic timed_out(input string what);
        fails++;
        $display("wrong value %s expected done seen timeout", what);
        end_of_test();
    endtask

    function automatic logic probe(input int which);
        case (which)
            0: return CONFIG_CLOCK_OUT;
            1: return BYTE_READ_STROBE;
            default: return CONFIG_CLOCK_IN;
        endcase
    endfunction

    task automatic wait_for(input int which, input logic lvl, output int n);
        n = 0;
        while (probe(which) !== lvl)
        begin
            tick();
            n++;
            if (n > 400)
                timed_out("edge wait");
        end
    endtask

    task automatic restart(input logic [1:0] mode, input logic rate);
        int n;
        @(posedge MCLK);
        PROGRAM_INPUT_N <= 1'b0;
        // mode pins move only in program
        MODE_SEL          <= mode;
        CLOCK_RATE_SELECT <= rate;
        slave_sel = mode[1];
        repeat (4) tick();
        `CHECK("init while held", 1'b0, INIT_DONE)
        `CHECK("strobe idle", 1'b1, BYTE_READ_STROBE)
        `CHECK("address start", 18'h0, MEM_ADDR)
        `CHECK("clock drive off", 1'b1, CONFIG_CLOCK_OE_N)
        @(posedge MCLK);
        PROGRAM_INPUT_N <= 1'b1;
        n = 0;
        while (INIT_DONE !== 1'b1)
        begin
            tick();
            n++;
            if (n > 5200)
                timed_out("init rise");
        end
        `CHECK("init delay in range", 1'b1, (n >= 1268 && n <= 5088))
    endtask

    task automatic test_reset();
        tick();
        `CHECK("reset clock", 1'b0, CONFIG_CLOCK_OUT)
        `CHECK("reset strobe", 1'b1, BYTE_READ_STROBE)
        `CHECK("reset address", 18'h0, MEM_ADDR)
        `CHECK("reset init", 1'b0, INIT_DONE)
        $display("test reset done");
    endtask

    task automatic test_master_serial();
        int n;
        restart(2'h0, 1'b1);
        wait_for(0, 1'b1, n);
        `CHECK("first clock delay ok", 1'b1, (n >= 22 && n <= 90))
        `CHECK("clock driven", 1'b0, CONFIG_CLOCK_OE_N)
        for (int k = 0; k < 12; k++)
        begin
            wait_for(0, 1'b0, n);
            `CHECK("slow high time", 8, n)
            `CHECK("serial forward", PAT[k], DAISY_OUT)
            wait_for(0, 1'b1, n);
            `CHECK("slow low time", 8, n)
        end
        $display("test master serial done");
    endtask

    task automatic test_master_parallel();
        int           n;
        logic [7:0]   exp_byte;
        logic [17:0]  a;
        restart(2'h1, 1'b0);
        wait_for(1, 1'b0, n);
        wait_for(1, 1'b1, n);
        `CHECK("strobe low time", 14, n)
        for (int t = 0; t < 48; t++)
        begin
            a = 18'((t - 3) / 16);
            exp_byte = (a[7:0] * 8'h1d) ^ 8'h5a;
            `CHECK("strobe level", (t % 16 < 2), BYTE_READ_STROBE)
            `CHECK("fast clock level", (t % 2 == 0), CONFIG_CLOCK_OUT)
            if (t % 16 == 0)
                `CHECK("address step", 18'(t / 16 + 1), MEM_ADDR)
            if (t >= 3)
                `CHECK("daisy byte bit", exp_byte[7 - ((t - 3) % 16) / 2], DAISY_OUT)
            tick();
        end
        $display("test master parallel done");
    endtask

    task automatic test_slave_serial();
        int n;
        // Program pulse lands mid-transfer of the parallel run
        restart(2'h2, 1'b0);
        // link held back two microseconds after init
        repeat (40) tick();
        link_run = 1'b1;
        for (int k = 0; k < 11; k++)
        begin
            wait_for(2, 1'b1, n);
            wait_for(2, 1'b0, n);
            if (k > 0)
                `CHECK("slave forward", PAT[k - 1], DAISY_OUT)
        end
        link_run = 1'b0;
        `CHECK("slave leaves clock", 1'b1, CONFIG_CLOCK_OE_N)
        $display("test slave serial done");
    endtask

    initial
    begin
        repeat (16) @(posedge MCLK);
        test_reset();
        @(posedge MCLK);
        SRST <= 1'b0;
        test_master_serial();
        test_master_parallel();
        test_slave_serial();
        end_of_test();
    end
endmodule
